// >>> design/icp_pkg.sv
package icp_pkg;
   // ----------------------------------------------------------------
   // Clock and register map
   // ----------------------------------------------------------------
   localparam int         CLK_MHZ        = 100;
   localparam logic [7:0] OFS_LINK_CTL   = 8'h06;
   localparam logic [7:0] OFS_FAR_ADDR   = 8'h07;
   localparam logic [7:0] OFS_MAP0       = 8'h08;
   localparam logic [7:0] OFS_MAP1       = 8'h09;
   localparam logic [7:0] OFS_ALIAS0     = 8'h10;
   localparam logic [7:0] OFS_ALIAS1     = 8'h11;
   localparam logic [7:0] RST_LINK_CTL   = 8'h00;
   localparam logic [7:0] RST_FAR_ADDR   = 8'h00;
   localparam logic [7:0] RST_MAP        = 8'h00;
   localparam logic [7:0] RST_ALIAS      = 8'h00;
   // Writable bits of the control register (flag bit 7 and bit 5 read only)
   localparam logic [7:0] CTL_WR_MASK    = 8'h5F;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SEQ_ERR_BIT    = 7;
   localparam int SEQ_CLR_BIT    = 6;
   localparam int SDA_DLY_LSB    = 3;
   localparam int FAR_WR_BLK_BIT = 2;
   localparam int TMR_FAST_BIT   = 1;
   localparam int TMR_OFF_BIT    = 0;
   localparam int FREEZE_BIT     = 0;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int SDA_DLY_BASE_NS = 250;
   localparam int SDA_DLY_STEP_NS = 50;
   localparam int WD_FAST_US      = 50;
   localparam int WD_SLOW_S       = 1;
   localparam int WD_FAST_CYC     = WD_FAST_US * CLK_MHZ;
   localparam int WD_SLOW_CYC     = WD_SLOW_S * 1000000 * CLK_MHZ;
   localparam int WD_CNT_W        = 27;
   localparam int RECOV_HALF_US   = 5;
   localparam int RECOV_HALF_CYC  = RECOV_HALF_US * CLK_MHZ;
   localparam int RECOV_PULSES    = 9;
   // Forward channel frame: 4-bit sequence, 1 type bit, 7-bit payload
   localparam int FR_LEN          = 12;
   localparam int FR_SEQ_W        = 4;
   typedef enum logic [1:0] {
      WD_WATCH = 2'b00,
      WD_FREE  = 2'b01,
      WD_RECOV = 2'b10
   } icp_wd_state_t;
   // SCL-to-SDA delay in cycles; least time, so rounded up
   function automatic int sda_dly_cyc(input logic [1:0] code);
      return ((SDA_DLY_BASE_NS + SDA_DLY_STEP_NS * int'(code)) * CLK_MHZ + 999) / 1000;
   endfunction : sda_dly_cyc
endpackage : icp_pkg

// >>> design/icp_fc_if.sv
`timescale 1ns/1ps
// Decoded forward channel events on ref_clk; valid and error are one-cycle pulses, value is held
interface icp_fc_if;
   logic       id_valid;
   logic [6:0] id_value;
   logic       seq_err;
   modport rx   (output id_valid, output id_value, output seq_err);
   modport core (input id_valid, input id_value, input seq_err);
endinterface : icp_fc_if

// >>> design/icp_fc_rx.sv
`timescale 1ns/1ps
module icp_fc_rx
   import icp_pkg::*;
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic nrst,
   // Forward channel pins
   input  wire logic link_clk,
   input  wire logic fc_frame,
   input  wire logic fc_data,
   // Decoded events
   icp_fc_if.rx      fc
);
   logic [2:0]          sy1_r;
   logic [2:0]          sy2_r;
   logic                lclk_q_r;
   logic                frame_q_r;
   logic [FR_LEN-1:0]   sh_r;
   logic [3:0]          cnt_r;
   logic [FR_SEQ_W-1:0] exp_r;
   logic                lclk_rise;
   logic                frame_end;
   logic                id_valid_r;
   logic [6:0]          id_value_r;
   logic                seq_err_r;

   // ----------------------------------------------------------------
   // Pin synchronisers and edge finding
   // ----------------------------------------------------------------
   // Two stages for link clock, frame and data
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sy1_r <= 3'b000;
         sy2_r <= 3'b000;
      end else begin
         sy1_r <= {link_clk, fc_frame, fc_data};
         sy2_r <= sy1_r;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         lclk_q_r  <= 1'b0;
         frame_q_r <= 1'b0;
      end else begin
         lclk_q_r  <= sy2_r[2];
         frame_q_r <= sy2_r[1];
      end
   end

   assign lclk_rise = sy2_r[2] & ~lclk_q_r;
   assign frame_end = frame_q_r & ~sy2_r[1];

   // ----------------------------------------------------------------
   // Frame shifter and sequence check
   // ----------------------------------------------------------------
   // Bits shift in MSB first on link clock rises inside a frame
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sh_r  <= '0;
         cnt_r <= 4'h0;
      end else if (frame_end) begin
         cnt_r <= 4'h0;
      end else if (sy2_r[1] && lclk_rise) begin
         sh_r  <= {sh_r[FR_LEN-2:0], sy2_r[0]};
         cnt_r <= cnt_r + 4'h1;
      end
   end

   // A short frame or an unexpected sequence number counts as an error
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         exp_r      <= '0;
         seq_err_r  <= 1'b0;
         id_valid_r <= 1'b0;
         id_value_r <= 7'h00;
      end else begin
         seq_err_r  <= 1'b0;
         id_valid_r <= 1'b0;
         if (frame_end) begin
            if (cnt_r != 4'(FR_LEN)) begin
               seq_err_r <= 1'b1;
            end else begin
               exp_r      <= sh_r[FR_LEN-1 -: FR_SEQ_W] + 4'h1;
               seq_err_r  <= (sh_r[FR_LEN-1 -: FR_SEQ_W] != exp_r);
               id_valid_r <= ~sh_r[7];
               id_value_r <= sh_r[6:0];
            end
         end
      end
   end

   assign fc.id_valid = id_valid_r;
   assign fc.id_value = id_value_r;
   assign fc.seq_err  = seq_err_r;
endmodule : icp_fc_rx

// >>> design/icp_proxy.sv
`timescale 1ns/1ps
// What this block does
// R1: Forward channel sequence error sets read-only status bit 7.
// R2: Writing one to bit 6 clears the sequence error flag.
// R3: SDA output lags SCL by 250, 300, 350 or 400 ns per bits 4:3.
// R4: With block bit set, writes from across the link to local registers are dropped.
// R5: Watchdog expires after about 50 us when fast bit is one, else about 1 s.
// R6: Timer-off bit 0 stops the bus watchdog.
// R7: SDA high and idle for the interval marks the bus free.
// R8: SDA low and idle for the interval triggers nine SCL recovery pulses.
// R9: Serializer address sits in bits 7:1; zero disables access to it.
// R10: Serializer address loads from the link once receive lock is seen.
// R11: Freeze bit 0 stops auto-loading and keeps the written address.
// R12: Software writing the address should also set the freeze bit.
// R13: Alias hit is rewritten to the slot's physical address before forwarding.
// R14: Addresses match each slot's alias; alias zero disables that slot.
module icp_proxy
   import icp_pkg::*;
#(
   parameter int WD_FAST_CYCLES = WD_FAST_CYC,
   parameter int WD_SLOW_CYCLES = WD_SLOW_CYC
) (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   // Register port
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic       reg_remote,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // Forward channel link
   input  wire logic       link_clk,
   input  wire logic       fc_frame,
   input  wire logic       fc_data,
   input  wire logic       rx_lock,
   // Address remap
   input  wire logic       map_req,
   input  wire logic [6:0] map_addr,
   output logic            fwd_valid,
   output logic      [6:0] fwd_addr,
   output logic            fwd_to_bridge,
   // Local bus pins
   input  wire logic       scl_in,
   output logic            scl_out,
   output logic            scl_oe,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic       sda_tx_low,
   output logic            bus_free,
   output logic            bus_recovering
);
   icp_fc_if fc ();

   logic [7:0]          ctl_r;
   logic                seq_err_r;
   logic [7:0]          far_r;
   logic [7:0]          map_r [2];
   logic [7:0]          alias_r [2];
   logic [7:0]          rdata_r;
   logic [2:0]          lock_sy_r;
   logic [1:0]          pin1_r;
   logic [1:0]          pin2_r;
   logic [1:0]          pin_q_r;
   logic                scl_fall;
   logic                act;
   logic                wr_ok;
   logic                far_sw_wr;
   logic [5:0]          dly_cnt_r;
   logic                sda_oe_r;
   logic                sda_out_r;
   icp_wd_state_t       state_r;
   logic [WD_CNT_W-1:0] idle_cnt_r;
   logic [WD_CNT_W-1:0] wd_lim;
   logic [9:0]          half_cnt_r;
   logic [3:0]          pulse_cnt_r;
   logic                scl_oe_r;
   logic                free_r;
   logic                recov_r;
   logic                fwd_valid_r;
   logic [6:0]          fwd_addr_r;
   logic                fwd_bridge_r;

   icp_fc_rx u_fc_rx (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .link_clk (link_clk),
      .fc_frame (fc_frame),
      .fc_data  (fc_data),
      .fc       (fc)
   );

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   // Far-side writes are dropped when blocked; local bus targets are not affected
   // R4: remote write block
   assign wr_ok     = reg_wr & ~(reg_remote & ctl_r[FAR_WR_BLK_BIT]);
   assign far_sw_wr = wr_ok & (reg_addr == OFS_FAR_ADDR);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctl_r      <= RST_LINK_CTL;
         map_r[0]   <= RST_MAP;
         map_r[1]   <= RST_MAP;
         alias_r[0] <= RST_ALIAS;
         alias_r[1] <= RST_ALIAS;
      end else if (wr_ok) begin
         unique case (reg_addr)
            OFS_LINK_CTL: ctl_r      <= reg_wdata & CTL_WR_MASK;
            OFS_MAP0:     map_r[0]   <= reg_wdata;
            OFS_MAP1:     map_r[1]   <= reg_wdata;
            OFS_ALIAS0:   alias_r[0] <= reg_wdata;
            OFS_ALIAS1:   alias_r[1] <= reg_wdata;
            default:      ;
         endcase
      end
   end

   // Sequence error flag; a new error in the clearing cycle is kept
   // R1: set on error
   // R2: clear by bit 6
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         seq_err_r <= 1'b0;
      end else if (fc.seq_err) begin
         seq_err_r <= 1'b1;
      end else if (wr_ok && reg_addr == OFS_LINK_CTL && reg_wdata[SEQ_CLR_BIT]) begin
         seq_err_r <= 1'b0;
      end
   end

   // Receive lock comes from another domain
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         lock_sy_r <= 3'b000;
      end else begin
         lock_sy_r <= {lock_sy_r[1:0], rx_lock};
      end
   end

   // Software write wins over a load arriving in the same cycle
   // R10: load on lock
   // R11: freeze holds
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         far_r <= RST_FAR_ADDR;
      end else if (far_sw_wr) begin
         far_r <= reg_wdata;
      end else if (fc.id_valid && lock_sy_r[1] && !far_r[FREEZE_BIT]) begin
         far_r <= {fc.id_value, far_r[FREEZE_BIT]};
      end
   end

   // Read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_r <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            OFS_LINK_CTL: rdata_r <= {seq_err_r, ctl_r[6:0]};
            OFS_FAR_ADDR: rdata_r <= far_r;
            OFS_MAP0:     rdata_r <= map_r[0];
            OFS_MAP1:     rdata_r <= map_r[1];
            OFS_ALIAS0:   rdata_r <= alias_r[0];
            OFS_ALIAS1:   rdata_r <= alias_r[1];
            default:      rdata_r <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Address remap
   // ----------------------------------------------------------------
   // Slot 0 has priority if both aliases match
   // R13: alias rewrite
   // R14: alias zero off
   // R9: zero address off
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         fwd_valid_r  <= 1'b0;
         fwd_addr_r   <= 7'h00;
         fwd_bridge_r <= 1'b0;
      end else begin
         fwd_valid_r  <= 1'b0;
         fwd_bridge_r <= 1'b0;
         if (map_req) begin
            if (alias_r[0][7:1] != 7'h00 && alias_r[0][7:1] == map_addr) begin
               fwd_valid_r <= 1'b1;
               fwd_addr_r  <= map_r[0][7:1];
            end else if (alias_r[1][7:1] != 7'h00 && alias_r[1][7:1] == map_addr) begin
               fwd_valid_r <= 1'b1;
               fwd_addr_r  <= map_r[1][7:1];
            end else if (far_r[7:1] != 7'h00 && far_r[7:1] == map_addr) begin
               fwd_valid_r  <= 1'b1;
               fwd_bridge_r <= 1'b1;
               fwd_addr_r   <= map_addr;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Bus pins, SDA delay and watchdog
   // ----------------------------------------------------------------
   // Two stages on SCL and SDA, then a copy for edge finding
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pin1_r  <= 2'b11;
         pin2_r  <= 2'b11;
         pin_q_r <= 2'b11;
      end else begin
         pin1_r  <= {scl_in, sda_in};
         pin2_r  <= pin1_r;
         pin_q_r <= pin2_r;
      end
   end

   assign scl_fall = pin_q_r[1] & ~pin2_r[1];
   assign act      = (pin_q_r != pin2_r);
   // R5: interval select
   assign wd_lim   = ctl_r[TMR_FAST_BIT] ? WD_CNT_W'(WD_FAST_CYCLES) : WD_CNT_W'(WD_SLOW_CYCLES);

   // SDA follows the request only after the set delay past each SCL fall
   // R3: SDA output delay
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dly_cnt_r <= 6'd0;
         sda_oe_r  <= 1'b0;
         sda_out_r <= 1'b0;
      end else if (recov_r) begin
         dly_cnt_r <= 6'd0;
         sda_oe_r  <= 1'b0;
      end else if (scl_fall) begin
         dly_cnt_r <= 6'(sda_dly_cyc(ctl_r[SDA_DLY_LSB +: 2]) - 1);
      end else if (dly_cnt_r != 6'd0) begin
         dly_cnt_r <= dly_cnt_r - 6'd1;
         if (dly_cnt_r == 6'd1) begin
            sda_oe_r <= sda_tx_low;
         end
      end
   end

   // Our own recovery clocks are not counted as bus activity
   // R6: timer off
   // R7: free bus
   // R8: nine pulses
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_r     <= WD_WATCH;
         idle_cnt_r  <= '0;
         half_cnt_r  <= 10'd0;
         pulse_cnt_r <= 4'd0;
         scl_oe_r    <= 1'b0;
         free_r      <= 1'b0;
         recov_r     <= 1'b0;
      end else if (ctl_r[TMR_OFF_BIT]) begin
         state_r    <= WD_WATCH;
         idle_cnt_r <= '0;
         scl_oe_r   <= 1'b0;
         free_r     <= 1'b0;
         recov_r    <= 1'b0;
      end else begin
         unique case (state_r)
            WD_WATCH: begin
               if (act) begin
                  idle_cnt_r <= '0;
               end else if (idle_cnt_r >= wd_lim - WD_CNT_W'(1)) begin
                  idle_cnt_r  <= '0;
                  half_cnt_r  <= 10'd0;
                  pulse_cnt_r <= 4'd0;
                  state_r     <= pin2_r[0] ? WD_FREE : WD_RECOV;
                  free_r      <= pin2_r[0];
                  recov_r     <= ~pin2_r[0];
               end else begin
                  idle_cnt_r <= idle_cnt_r + WD_CNT_W'(1);
               end
            end
            WD_FREE: begin
               if (act) begin
                  state_r <= WD_WATCH;
                  free_r  <= 1'b0;
               end
            end
            WD_RECOV: begin
               if (half_cnt_r != 10'(RECOV_HALF_CYC - 1)) begin
                  half_cnt_r <= half_cnt_r + 10'd1;
               end else begin
                  half_cnt_r <= 10'd0;
                  if (!scl_oe_r && pulse_cnt_r == 4'(RECOV_PULSES)) begin
                     state_r <= WD_WATCH;
                     recov_r <= 1'b0;
                  end else begin
                     scl_oe_r    <= ~scl_oe_r;
                     pulse_cnt_r <= pulse_cnt_r + {3'd0, ~scl_oe_r};
                  end
               end
            end
            default: begin
               state_r <= WD_WATCH;
               recov_r <= 1'b0;
               free_r  <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata      = rdata_r;
   assign fwd_valid      = fwd_valid_r;
   assign fwd_addr       = fwd_addr_r;
   assign fwd_to_bridge  = fwd_bridge_r;
   assign scl_out        = sda_out_r;
   assign scl_oe         = scl_oe_r;
   assign sda_out        = sda_out_r;
   assign sda_oe         = sda_oe_r;
   assign bus_free       = free_r;
   assign bus_recovering = recov_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence s_expire;
      state_r == WD_WATCH && !ctl_r[TMR_OFF_BIT] && !act && idle_cnt_r == wd_lim - WD_CNT_W'(1);
   endsequence
   sequence s_recov_done;
      state_r == WD_RECOV && !ctl_r[TMR_OFF_BIT] ##1 state_r == WD_WATCH;
   endsequence

   AST_SEQ_SET: assert property (fc.seq_err |=> seq_err_r) // R1
      else $error("sequence error not flagged");
   AST_SEQ_CLR: assert property (!fc.seq_err && wr_ok && reg_addr == OFS_LINK_CTL // R2
      && reg_wdata[SEQ_CLR_BIT] |=> !seq_err_r)
      else $error("sequence error not cleared");
   AST_SDA_DLY: assert property (scl_fall && ctl_r[4:3] == 2'b00 && !recov_r ##1 (!scl_fall && !recov_r)[*8] // R3
      ##1 (!scl_fall && !recov_r)[*8] ##1 (!scl_fall && !recov_r)[*8] |=> sda_oe_r == $past(sda_tx_low))
      else $error("SDA delay wrong for code 00");
   AST_FAR_BLOCK: assert property (reg_wr && reg_remote && ctl_r[FAR_WR_BLK_BIT] // R4
      |=> $stable(ctl_r) && $stable(far_r[7:1]) || $past(fc.id_valid))
      else $error("remote write not blocked");
   AST_WD_EXPIRE: assert property (s_expire |=> state_r != WD_WATCH) // R5
      else $error("watchdog did not expire");
   AST_WD_OFF: assert property (ctl_r[TMR_OFF_BIT] |=> idle_cnt_r == '0 && !scl_oe_r) // R6
      else $error("watchdog runs while off");
   AST_FREE: assert property (s_expire ##0 pin2_r[0] |=> free_r && !recov_r) // R7
      else $error("free bus not flagged");
   AST_RECOV: assert property (s_recov_done |-> $past(pulse_cnt_r) == 4'd9 && !scl_oe_r) // R8
      else $error("recovery pulse count wrong");
   AST_ID_LOAD: assert property (fc.id_valid && lock_sy_r[1] && !far_r[FREEZE_BIT] && !far_sw_wr // R10
      |=> far_r[7:1] == $past(fc.id_value))
      else $error("address not loaded on lock");
   AST_FREEZE: assert property (far_r[FREEZE_BIT] && !far_sw_wr |=> $stable(far_r)) // R11
      else $error("frozen address changed");
   AST_REMAP: assert property (map_req && alias_r[0][7:1] != 7'h00 && alias_r[0][7:1] == map_addr // R13
      |=> fwd_valid_r && fwd_addr_r == $past(map_r[0][7:1]))
      else $error("alias not remapped");
   AST_ZERO_OFF: assert property (map_req && alias_r[0][7:1] == 7'h00 && alias_r[1][7:1] == 7'h00 // R14
      && far_r[7:1] == 7'h00 |=> !fwd_valid_r)
      else $error("zero address forwarded");
endmodule : icp_proxy

// >>> verif/icp_far_ser.sv
`timescale 1ns/1ps
// Far serializer: sends forward channel frames, MSB first
module icp_far_ser (
   // Link pins
   output logic link_clk,
   output logic fc_frame,
   output logic fc_data
);
   initial begin
      link_clk = 1'b0;
      fc_frame = 1'b0;
      fc_data  = 1'b1;
   end
   // Link clock only runs inside a frame; nb below 12 makes a short frame
   task automatic send(input logic [11:0] fr, input int nb);
      fc_frame = 1'b1;
      for (int i = nb - 1; i >= 0; i--) begin
         fc_data = fr[i];
         #40 link_clk = 1'b1;
         #40 link_clk = 1'b0;
      end
      #40 fc_frame = 1'b0;
      // Released line must not keep the last bit
      fc_data = ~fc_data;
      #80;
   endtask : send
endmodule : icp_far_ser

// >>> verif/icp_proxy_tb_top.sv
`timescale 1ns/1ps
module icp_proxy_tb_top import icp_pkg::*; ;
   logic       ref_clk, nrst, reg_wr, reg_rd, reg_remote, rx_lock, map_req;
   logic       scl_drv, sda_drv, sda_tx_low, link_clk, fc_frame, fc_data;
   logic       fwd_valid, fwd_to_bridge, scl_out, scl_oe, sda_out, sda_oe;
   logic       bus_free, bus_recovering, rd_seen;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [6:0] map_addr, fwd_addr, al, ph, fid;
   logic [7:0] rq[$], fq[$];
   logic [7:0] offs[6] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h10, 8'h20};
   int         fails, tests_run, cyc, n, k, d[4];
   wire  [2:0] obs = {bus_recovering, bus_free, sda_oe};
   // Open-drain pins: low if anyone pulls
   icp_proxy #(.WD_FAST_CYCLES(200), .WD_SLOW_CYCLES(400)) icp_proxy_inst (
      .ref_clk, .nrst, .reg_wr, .reg_rd, .reg_remote, .reg_addr, .reg_wdata,
      .reg_rdata, .link_clk, .fc_frame, .fc_data, .rx_lock, .map_req, .map_addr,
      .fwd_valid, .fwd_addr, .fwd_to_bridge, .scl_in(scl_drv & ~scl_oe), .scl_out,
      .scl_oe, .sda_in(sda_drv & ~sda_oe), .sda_out, .sda_oe, .sda_tx_low,
      .bus_free, .bus_recovering);
   icp_far_ser icp_far_ser_inst (.link_clk, .fc_frame, .fc_data);
   always #5 ref_clk = ~ref_clk;
   // Hang guard, well above the recovery run
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 60000) begin
         fails++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      tests_run++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // Results are matched against the oldest note as they appear
   always @(posedge ref_clk) begin
      if (rd_seen === 1'b1)
         chk("rdata", reg_rdata, rq.pop_front());
      if (fwd_valid === 1'b1)
         chk("fwd", {fwd_to_bridge, fwd_addr}, fq.size() ? fq.pop_front() : 8'hxx);
      rd_seen <= reg_rd;
   end
   // Trailing edge keeps strobes from being set twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic rm = 1'b0);
      reg_addr   <= a;
      reg_wdata  <= v;
      reg_remote <= rm;
      reg_wr     <= 1'b1;
      @(posedge ref_clk);
      reg_wr     <= 1'b0;
      @(posedge ref_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rq.push_back(e);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      @(posedge ref_clk);
   endtask : rd
   task automatic map(input logic [6:0] a, input logic [7:0] e, input logic hit);
      if (hit)
         fq.push_back(e);
      map_addr <= a;
      map_req  <= 1'b1;
      @(posedge ref_clk);
      map_req  <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask : map
   // Cycles until a watched output rises, capped
   task automatic upto(input int w, input int lim);
      n = 0;
      while (obs[w] !== 1'b1 && n < lim) begin
         @(posedge ref_clk);
         n++;
      end
   endtask : upto
   initial begin
      {ref_clk, nrst, reg_wr, reg_rd, reg_remote, rx_lock, map_req} = '0;
      {sda_tx_low, reg_addr, reg_wdata, map_addr} = '0;
      {scl_drv, sda_drv} = 2'b11;
      void'($urandom(77));
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      foreach (offs[i]) rd(offs[i], 8'h00);
      wr(OFS_LINK_CTL, 8'hFF);
      rd(OFS_LINK_CTL, CTL_WR_MASK);
      // Far master writes dropped while blocked, taken once unblocked
      wr(OFS_LINK_CTL, 8'h04);
      wr(OFS_MAP0, 8'h22, 1'b1);
      rd(OFS_MAP0, 8'h00);
      wr(OFS_LINK_CTL, 8'h00);
      wr(OFS_MAP1, 8'h22, 1'b1);
      rd(OFS_MAP1, 8'h22);
      al = 7'($urandom_range(127, 1));
      ph = 7'($urandom);
      wr(OFS_ALIAS0, {al, 1'b0});
      wr(OFS_MAP0, {ph, 1'b0});
      map(al, {1'b0, ph}, 1'b1);
      wr(OFS_ALIAS0, 8'h00);
      map(al, 8'h00, 1'b0);
      // Far address loads after lock and then addresses the bridge
      rx_lock <= 1'b1;
      fid = 7'($urandom_range(127, 1));
      icp_far_ser_inst.send({4'h0, 1'b0, fid}, 12);
      repeat (8) @(posedge ref_clk);
      rd(OFS_FAR_ADDR, {fid, 1'b0});
      map(fid, {1'b1, fid}, 1'b1);
      icp_far_ser_inst.send({4'h1, 1'b0, fid}, 11);
      repeat (8) @(posedge ref_clk);
      rd(OFS_LINK_CTL, 8'h80);
      wr(OFS_LINK_CTL, 8'h40);
      rd(OFS_LINK_CTL, 8'h40);
      wr(OFS_FAR_ADDR, {~fid, 1'b1});
      icp_far_ser_inst.send({4'h1, 1'b0, fid}, 12);
      repeat (8) @(posedge ref_clk);
      rd(OFS_FAR_ADDR, {~fid, 1'b1});
      wr(OFS_FAR_ADDR, 8'h00);
      map(7'h00, 8'h00, 1'b0);
      // SDA lag per code, watchdog off so it cannot interfere
      for (int c = 0; c < 4; c++) begin
         wr(OFS_LINK_CTL, 8'(c * 8 + 1));
         sda_tx_low <= 1'b1;
         scl_drv    <= 1'b0;
         upto(0, 80);
         d[c] = n;
         chk("lag", 8'(d[c] - d[0]), 8'(5 * c));
         chk("lag0", 8'(d[0] inside {[25:30]}), 8'h01);
         sda_tx_low <= 1'b0;
         scl_drv    <= 1'b1;
         repeat (5) @(posedge ref_clk);
         scl_drv    <= 1'b0;
         repeat (60) @(posedge ref_clk);
         scl_drv    <= 1'b1;
      end
      wr(OFS_LINK_CTL, 8'h02);
      sda_drv <= 1'b0;
      @(posedge ref_clk);
      sda_drv <= 1'b1;
      upto(1, 400);
      chk("free", 8'(n inside {[198:210]}), 8'h01);
      sda_drv <= 1'b0;
      upto(2, 400);
      chk("hang", 8'(n inside {[198:210]}), 8'h01);
      // Count SCL pulls until recovery ends
      {k, n, d[0]} = '0;
      while (bus_recovering === 1'b1 && k < 12000) begin
         @(posedge ref_clk);
         k++;
         if (scl_oe === 1'b1 && n == 0)
            d[0]++;
         n = int'(scl_oe === 1'b1);
      end
      chk("pulses", 8'(d[0]), 8'(RECOV_PULSES));
      chk("odrain", {6'h00, scl_out, sda_out}, 8'h00);
      wr(OFS_LINK_CTL, 8'h03);
      k = 0;
      repeat (600) begin
         @(posedge ref_clk);
         k += int'(bus_recovering !== 1'b0 || scl_oe !== 1'b0 || bus_free !== 1'b0);
      end
      chk("off", 8'(k), 8'h00);
      // Slow interval with the timer back on and SDA released
      wr(OFS_LINK_CTL, 8'h00);
      sda_drv <= 1'b1;
      upto(1, 800);
      chk("slow", 8'(n inside {[398:410]}), 8'h01);
      chk("left", 8'(rq.size() + fq.size()), 8'h00);
      conclude();
   end
endmodule : icp_proxy_tb_top
